// file: hdl/vic_top.v
// Vectored interrupt control with AXI4-Lite register access and core sequencer handshake.
`timescale 1ns/10ps
`include "vic_regs.vh"
// Function
// R1: Twelve sources, each held in its own flag bit.
// R2: Flags set on events regardless of masks or global enable.
// R3: Global enable in control bit 7 allows unmasked sources or blocks all.
// R4: Enabled flagged and masked source requests vectoring at once.
// R5: Every reset clears the global enable.
// R6: Return-from-interrupt sets the global enable again.
// R7: Pin, port change and timer flags live in the main control register.
// R8: Peripheral flags and masks in two register pairs, gated by group enable.
// R9: Acknowledge clears global enable, pushes return address, jumps to 0004h.
// R10: External event to vector latency is three or four instruction cycles.
// R11: Latency independent of one or two cycle instructions.
// R12: Software clears serviced flags before re-enabling interrupts.
// R13: Software polls flags to find sources sharing one vector.
// R14: Wake from sleep with enable set runs PC+1 then jumps to vector.
// R15: Wake-up sets flag bits and leaves enable bits unchanged.
// R16: Software repeats clearing global enable until read-back shows clear.
// R17: Pin interrupt on rising or falling edge by edge select sets bit 1.
// R18: Timer0 wrap from FFh to 00h sets bit 2; its mask is bit 5.
// R19: Change on upper four port pins sets port change flag bit 0.
// R20: Enabled pin interrupt wakes from sleep; global enable decides vectoring.
// R21: Request is global enable AND OR of enabled core and gated peripheral pairs.
module vic_top
(
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ext_irq_pin_i,
  input  wire [3:0]  port_hi_pins_i,
  input  wire [7:0]  timer0_count_i,
  input  wire [7:0]  periph_event_a_i,
  input  wire        periph_event_b_i,
  input  wire        instr_cycle_i,
  input  wire        sleeping_i,
  input  wire        return_from_irq_instr_i,
  input  wire        gie_clear_instr_i,
  input  wire [12:0] pc_i,
  output wire        irq_request_o,
  output wire        wake_o,
  output reg         vector_load_o,
  output reg  [12:0] vector_addr_o,
  output reg         stack_push_o,
  output reg  [12:0] return_addr_o
);
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_WAKE = 2'b10;

  reg [7:0]                  ctrl_reg;
  reg [`VIC_PFLAG_A_W-1:0]   pflag_a_reg;
  reg [`VIC_PFLAG_B_W-1:0]   pflag_b_reg;
  reg [`VIC_PFLAG_A_W-1:0]   pmask_a_reg;
  reg [`VIC_PFLAG_B_W-1:0]   pmask_b_reg;
  reg [7:0]                  option_reg;
  reg [7:0]                  tmr_prev_reg;
  reg [3:0]                  port_last_reg;
  reg [1:0]                  state_reg;
  reg                        ack_cnt_reg;
  reg                        aw_held_reg;
  reg [7:0]                  aw_addr_reg;
  reg                        w_held_reg;
  reg [31:0]                 w_data_reg;
  reg [3:0]                  w_strb_reg;
  wire                       ext_level;
  wire                       ext_rise;
  wire                       ext_fall;
  wire [3:0]                 port_level;
  wire                       port_change;
  wire                       ext_event;
  wire                       tmr_event;
  wire                       core_pend;
  wire                       peri_pend;
  wire                       wr_fire;
  wire                       rd_fire;
  wire [`VIC_PFLAG_A_W-1:0]  pflag_a_next;
  wire [`VIC_PFLAG_B_W-1:0]  pflag_b_next;

  // Masks a byte with write strobe lane 0.
  function [7:0] merge_byte;
    input [7:0] old_val;
    input [7:0] new_val;
    input       lane;
    begin
      merge_byte = lane ? new_val : old_val;
    end
  endfunction

  // Tells whether a write address selects the register at the given offset.
  function wr_hit;
    input [`VIC_ADDR_W-1:0] addr;
    input [`VIC_ADDR_W-1:0] off;
    begin
      wr_hit = (addr == off);
    end
  endfunction

  vic_pin_sync u_ext_sync
  (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (ext_irq_pin_i),
    .level_o (ext_level),
    .rise_o  (ext_rise),
    .fall_o  (ext_fall)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_port
      vic_pin_sync u_port_sync
      (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (port_hi_pins_i[gi]),
        .level_o (port_level[gi]),
        .rise_o  (),
        .fall_o  ()
      );
    end
  endgenerate

  assign ext_event   = option_reg[`VIC_BIT_EDGE_SEL] ? ext_rise : ext_fall; // R17
  assign port_change = |(port_level ^ port_last_reg); // R19
  assign tmr_event   = (tmr_prev_reg == `VIC_TMR_MAX) && (timer0_count_i == `VIC_TMR_WRAP); // R18
  assign core_pend   = (ctrl_reg[`VIC_BIT_PORT_FLAG] & ctrl_reg[`VIC_BIT_PORT_MASK]) |
                       (ctrl_reg[`VIC_BIT_EXT_FLAG] & ctrl_reg[`VIC_BIT_EXT_MASK]) |
                       (ctrl_reg[`VIC_BIT_TMR_FLAG] & ctrl_reg[`VIC_BIT_TMR_MASK]); // R7
  assign peri_pend   = ctrl_reg[`VIC_BIT_PERI_EN] &
                       (|(pflag_a_reg & pmask_a_reg) | |(pflag_b_reg & pmask_b_reg)); // R8
  assign irq_request_o = ctrl_reg[`VIC_BIT_GIE] & (core_pend | peri_pend); // R3 R4 R21
  assign wake_o        = sleeping_i & (core_pend | peri_pend); // R20
  assign pflag_a_next  = (wr_fire && wr_hit(aw_addr_reg, `VIC_OFF_PFLAG_A) ?
                          merge_byte(pflag_a_reg, w_data_reg[7:0], w_strb_reg[0]) : pflag_a_reg) | periph_event_a_i; // R1 R15
  assign pflag_b_next  = (wr_fire && wr_hit(aw_addr_reg, `VIC_OFF_PFLAG_B) && w_strb_reg[0] ?
                          w_data_reg[0] : pflag_b_reg) | periph_event_b_i; // R1

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl_reg      <= `VIC_RST_CTRL; // R5
      pflag_a_reg   <= {`VIC_PFLAG_A_W{1'b0}};
      pflag_b_reg   <= {`VIC_PFLAG_B_W{1'b0}};
      pmask_a_reg   <= {`VIC_PFLAG_A_W{1'b0}};
      pmask_b_reg   <= {`VIC_PFLAG_B_W{1'b0}};
      option_reg    <= `VIC_RST_OPTION;
      tmr_prev_reg  <= `VIC_RST_PERIPH;
      port_last_reg <= 4'h0;
      state_reg     <= ST_IDLE;
      ack_cnt_reg   <= 1'b0;
      vector_load_o <= 1'b0;
      vector_addr_o <= 13'h0000;
      stack_push_o  <= 1'b0;
      return_addr_o <= 13'h0000;
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_held_reg    <= 1'b0;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `VIC_RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `VIC_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
    end
    else
    begin
      tmr_prev_reg  <= timer0_count_i;
      port_last_reg <= port_level;
      vector_load_o <= 1'b0;
      stack_push_o  <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `VIC_RESP_OKAY;
        case (aw_addr_reg)
          `VIC_OFF_CTRL:    ctrl_reg    <= merge_byte(ctrl_reg, w_data_reg[7:0], w_strb_reg[0]);
          `VIC_OFF_PFLAG_A: pflag_a_reg <= merge_byte(pflag_a_reg, w_data_reg[7:0], w_strb_reg[0]);
          `VIC_OFF_PFLAG_B: pflag_b_reg <= w_strb_reg[0] ? w_data_reg[0] : pflag_b_reg;
          `VIC_OFF_PMASK_A: pmask_a_reg <= merge_byte(pmask_a_reg, w_data_reg[7:0], w_strb_reg[0]);
          `VIC_OFF_PMASK_B: pmask_b_reg <= w_strb_reg[0] ? w_data_reg[0] : pmask_b_reg;
          `VIC_OFF_OPTION:  option_reg  <= merge_byte(option_reg, w_data_reg[7:0], w_strb_reg[0]);
          `VIC_OFF_STATUS:  s_axi_bresp <= `VIC_RESP_OKAY;
          default:          s_axi_bresp <= `VIC_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (gie_clear_instr_i)
        ctrl_reg[`VIC_BIT_GIE] <= 1'b0;
      if (return_from_irq_instr_i)
        ctrl_reg[`VIC_BIT_GIE] <= 1'b1; // R6
      // Hardware set of a flag wins over a software clear in the same cycle.
      if (ext_event)
        ctrl_reg[`VIC_BIT_EXT_FLAG] <= 1'b1; // R2 R17
      if (port_change)
        ctrl_reg[`VIC_BIT_PORT_FLAG] <= 1'b1; // R19
      if (tmr_event)
        ctrl_reg[`VIC_BIT_TMR_FLAG] <= 1'b1; // R18
      pflag_a_reg <= pflag_a_next; // R2
      pflag_b_reg <= pflag_b_next; // R2
      // Acknowledge waits for an instruction cycle boundary so latency is the same for any instruction.
      // A request is taken at the second boundary in wait; the boundary that ends sleep counts as the first.
      case (state_reg)
        ST_IDLE:
        begin
          ack_cnt_reg <= 1'b0;
          if (irq_request_o && sleeping_i)
            state_reg <= ST_WAKE; // R14
          else if (irq_request_o)
            state_reg <= ST_WAIT; // R10
        end
        ST_WAKE:
        begin
          if (!sleeping_i && instr_cycle_i)
          begin
            state_reg   <= ST_WAIT; // R14
            ack_cnt_reg <= `VIC_ACK_LAST; // R14
          end
        end
        ST_WAIT:
        begin
          if (instr_cycle_i && ack_cnt_reg == `VIC_ACK_LAST)
          begin
            ack_cnt_reg              <= 1'b0;
            state_reg                <= ST_IDLE; // R11
            ctrl_reg[`VIC_BIT_GIE]   <= 1'b0; // R9
            stack_push_o             <= 1'b1; // R9
            return_addr_o            <= pc_i;
            vector_load_o            <= 1'b1;
            vector_addr_o            <= `VIC_VECTOR; // R9
          end
          else if (!irq_request_o)
          begin
            state_reg   <= ST_IDLE;
            ack_cnt_reg <= 1'b0;
          end
          else if (instr_cycle_i)
            ack_cnt_reg <= `VIC_ACK_LAST; // R10
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `VIC_RESP_OKAY;
        case (s_axi_araddr)
          `VIC_OFF_CTRL:    s_axi_rdata <= {24'h000000, ctrl_reg}; // R13
          `VIC_OFF_PFLAG_A: s_axi_rdata <= {24'h000000, pflag_a_reg};
          `VIC_OFF_PFLAG_B: s_axi_rdata <= {31'h00000000, pflag_b_reg};
          `VIC_OFF_PMASK_A: s_axi_rdata <= {24'h000000, pmask_a_reg};
          `VIC_OFF_PMASK_B: s_axi_rdata <= {31'h00000000, pmask_b_reg};
          `VIC_OFF_OPTION:  s_axi_rdata <= {24'h000000, option_reg};
          `VIC_OFF_STATUS:  s_axi_rdata <= {27'h0000000, ext_level, irq_request_o, wake_o, state_reg};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `VIC_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// file: hdl/vic_regs.vh
// Register offsets, field positions, reset values and timing counts of the vectored interrupt control.
`ifndef VIC_REGS_VH
`define VIC_REGS_VH
`define VIC_ADDR_W        8
`define VIC_OFF_CTRL      8'h00
`define VIC_OFF_PFLAG_A   8'h04
`define VIC_OFF_PFLAG_B   8'h08
`define VIC_OFF_PMASK_A   8'h0c
`define VIC_OFF_PMASK_B   8'h10
`define VIC_OFF_OPTION    8'h14
`define VIC_OFF_STATUS    8'h18
`define VIC_BIT_PORT_FLAG 0
`define VIC_BIT_EXT_FLAG  1
`define VIC_BIT_TMR_FLAG  2
`define VIC_BIT_PORT_MASK 3
`define VIC_BIT_EXT_MASK  4
`define VIC_BIT_TMR_MASK  5
`define VIC_BIT_PERI_EN   6
`define VIC_BIT_GIE       7
`define VIC_BIT_EDGE_SEL  6
`define VIC_RST_CTRL      8'h00
`define VIC_RST_PERIPH    8'h00
`define VIC_RST_OPTION    8'hff
`define VIC_PFLAG_A_W     8
`define VIC_PFLAG_B_W     1
`define VIC_VECTOR        13'h0004
`define VIC_TMR_MAX       8'hff
`define VIC_TMR_WRAP      8'h00
`define VIC_ACK_LAST      1'b1
`define VIC_CYC_PER_INSTR 3'd4
`define VIC_RESP_OKAY     2'b00
`define VIC_RESP_SLVERR   2'b10
`endif

// file: hdl/vic_pin_sync.v
// Three-stage pin synchroniser that reports a settled level and its edges.
`timescale 1ns/10ps
module vic_pin_sync
(
  input  wire clk_i,
  input  wire reset_i,
  input  wire pin_i,
  output reg  level_o,
  output wire rise_o,
  output wire fall_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      level_o <= 1'b0;
    end
    else
    begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        level_o <= s3_reg;
    end
  end
  assign rise_o = (s2_reg == s3_reg) && s3_reg && !level_o;
  assign fall_o = (s2_reg == s3_reg) && !s3_reg && level_o;
endmodule

// file: tb/vic_core_model.sv
// Behavioural core sequencer: instruction-cycle pulses and program counter.
`timescale 1ns/10ps
`include "vic_regs.vh"
module vic_core_model
(
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        vector_load_i,
  output reg         instr_cycle_o,
  output reg  [12:0] pc_o
);
  reg [1:0] ph_reg;
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ph_reg        <= 2'h0;
      instr_cycle_o <= 1'b0;
      pc_o          <= 13'h0100;
    end
    else
    begin
      ph_reg        <= ph_reg + 2'h1;
      instr_cycle_o <= (ph_reg == 2'h3);
      if (vector_load_i)
        pc_o <= `VIC_VECTOR;
      else if (ph_reg == 2'h3)
        pc_o <= pc_o + 13'h1;
    end
  end
endmodule

// file: tb/vic_top_asserts.sv
// Concurrent checks on the vectored interrupt control ports.
`timescale 1ns/10ps
module vic_top_asserts
(
  input wire        clk_i,
  input wire        reset_i,
  input wire        instr_cycle_i,
  input wire        sleeping_i,
  input wire [12:0] pc_i,
  input wire        irq_request_o,
  input wire        wake_o,
  input wire        vector_load_o,
  input wire [12:0] vector_addr_o,
  input wire        stack_push_o,
  input wire [12:0] return_addr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_reset_gie_off: assert property ($past(reset_i) |-> !irq_request_o)
    else $error("request right after reset");
  a_vector_addr: assert property (vector_load_o |-> vector_addr_o == 13'h0004)
    else $error("wrong vector");
  a_push_addr: assert property (stack_push_o |-> return_addr_o == $past(pc_i))
    else $error("wrong return address");
  a_ack_clears_gie: assert property (vector_load_o |-> !irq_request_o && stack_push_o)
    else $error("request stays after acknowledge");
  a_ack_one_pulse: assert property (vector_load_o |=> !vector_load_o [*3])
    else $error("vector load too long");
  a_ack_had_req: assert property ($rose(vector_load_o) |-> $past(irq_request_o))
    else $error("acknowledge without request");
  a_ack_on_boundary: assert property ($rose(vector_load_o) |-> $past(instr_cycle_i))
    else $error("acknowledge off boundary");
  a_req_vectors_soon: assert property ($rose(irq_request_o) && !sleeping_i |-> ##[1:12] vector_load_o)
    else $error("request not served");
  a_wake_in_sleep: assert property (wake_o |-> sleeping_i)
    else $error("wake while awake");
  a_no_vector_asleep: assert property (vector_load_o |-> !$past(sleeping_i))
    else $error("vector during sleep");
  c_ack: cover property (vector_load_o);
  c_wake: cover property (wake_o);
  c_req: cover property ($rose(irq_request_o));
endmodule
bind vic_top vic_top_asserts vic_top_asserts_inst (.clk_i(clk_i), .reset_i(reset_i),
  .instr_cycle_i(instr_cycle_i), .sleeping_i(sleeping_i), .pc_i(pc_i), .irq_request_o(irq_request_o),
  .wake_o(wake_o), .vector_load_o(vector_load_o), .vector_addr_o(vector_addr_o),
  .stack_push_o(stack_push_o), .return_addr_o(return_addr_o));

// file: tb/vic_top_tb.sv
// Self-checking bench for the vectored interrupt control.
`timescale 1ns/10ps
`include "vic_regs.vh"
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module vic_top_tb;
  logic        clk_i = 0, reset_i = 1;
  logic [7:0]  awa = 0, ara = 0, tmr = 0, eva = 0;
  logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0, pin = 0, slp = 0, rfi = 0, evb = 0, gcl = 0;
  logic [31:0] wd = 0, d;
  logic [3:0]  ph = 0;
  logic [1:0]  r;
  wire         awr, wr, bv, arr, rv, icyc, irq, wake, vl, sp;
  wire  [1:0]  brs, rrs;
  wire  [31:0] rdat;
  wire  [12:0] pc, va, ra;
  int          mismatches = 0, comparisons = 0, cyc = 0, k;
  vic_top vic_top_inst (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .ext_irq_pin_i(pin), .port_hi_pins_i(ph), .timer0_count_i(tmr), .periph_event_a_i(eva),
    .periph_event_b_i(evb), .instr_cycle_i(icyc), .sleeping_i(slp), .return_from_irq_instr_i(rfi),
    .gie_clear_instr_i(gcl), .pc_i(pc), .irq_request_o(irq), .wake_o(wake), .vector_load_o(vl),
    .vector_addr_o(va), .stack_push_o(sp), .return_addr_o(ra));
  vic_core_model vic_core_model_inst (.clk_i(clk_i), .reset_i(reset_i), .vector_load_i(vl),
    .instr_cycle_o(icyc), .pc_o(pc));
  initial forever #10 clk_i = ~clk_i;
  task bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    logic ad, dd, qd, fin;
    begin
      fin = 0;
      @(posedge clk_i);
      awa <= a;
      ara <= a;
      wd  <= {24'h0, v};
      awv <= w;
      wv  <= w;
      br  <= w;
      arv <= !w;
      rr  <= !w;
      while (!fin)
      begin
        @(negedge clk_i);
        ad  = awv & awr;
        dd  = wv & wr;
        qd  = arv & arr;
        fin = w ? bv : rv;
        r   = w ? brs : rrs;
        d   = rdat;
        @(posedge clk_i);
        if (ad) awv <= 0;
        if (dd) wv <= 0;
        if (qd) arv <= 0;
        if (fin) {br, rr} <= 2'b00;
      end
    end
  endtask
  task wait_vl;
    begin
      k = 0;
      while (vl !== 1'b1)
      begin
        @(negedge clk_i);
        if (icyc) k++;
      end
    end
  endtask
  task t_reset;
    begin
      bus(0, `VIC_OFF_CTRL, 0);
      `CHK("ctrl", 32'h0, d)
      bus(0, `VIC_OFF_OPTION, 0);
      `CHK("option", 32'hff, d)
      bus(0, 8'h40, 0);
      `CHK("unmapped", `VIC_RESP_SLVERR, r)
      $display("t_reset done");
    end
  endtask
  task t_flags;
    begin
      @(posedge clk_i);
      {eva, evb, tmr, pin, ph} <= {8'h08, 1'b1, 8'hff, 1'b1, 4'h5};
      @(posedge clk_i);
      {eva, evb, tmr} <= 17'h00000;
      repeat (6) @(posedge clk_i);
      bus(0, `VIC_OFF_PFLAG_A, 0);
      `CHK("pflag_a", 32'h08, d)
      bus(0, `VIC_OFF_PFLAG_B, 0);
      `CHK("pflag_b", 32'h1, d)
      bus(0, `VIC_OFF_CTRL, 0);
      `CHK("ctrl", 32'h07, d)
      `CHK("irq", 1'b0, irq)
      $display("t_flags done");
    end
  endtask
  task t_vector;
    begin
      bus(1, `VIC_OFF_CTRL, 8'h00);
      bus(1, `VIC_OFF_PMASK_A, 8'h08);
      `CHK("bresp", `VIC_RESP_OKAY, r)
      bus(1, `VIC_OFF_CTRL, 8'h80);
      `CHK("gated", 1'b0, irq)
      bus(1, `VIC_OFF_CTRL, 8'hc0);
      `CHK("irq", 1'b1, irq)
      wait_vl;
      `CHK("vector", `VIC_VECTOR, va)
      `CHK("latency", 2, k)
      `CHK("push", 1'b1, sp)
      `CHK("ret addr", pc, ra)
      bus(0, `VIC_OFF_CTRL, 0);
      `CHK("gie off", 32'h40, d)
      bus(1, `VIC_OFF_PFLAG_A, 8'h00);
      @(posedge clk_i);
      rfi <= 1;
      @(posedge clk_i);
      rfi <= 0;
      bus(0, `VIC_OFF_CTRL, 0);
      `CHK("gie on", 32'hc0, d)
      `CHK("no req", 1'b0, irq)
      @(posedge clk_i);
      gcl <= 1;
      @(posedge clk_i);
      gcl <= 0;
      bus(0, `VIC_OFF_CTRL, 0);
      `CHK("gie cleared", 32'h40, d)
      $display("t_vector done");
    end
  endtask
  task t_sleep;
    begin
      bus(1, `VIC_OFF_CTRL, 8'h10);
      bus(1, `VIC_OFF_OPTION, 8'hbf);
      slp <= 1;
      pin <= 0;
      repeat (6) @(posedge clk_i);
      `CHK("wake", 1'b1, wake)
      `CHK("irq", 1'b0, irq)
      bus(1, `VIC_OFF_CTRL, 8'h92);
      repeat (12) @(posedge clk_i);
      slp <= 0;
      wait_vl;
      `CHK("pc+1", 2, k)
      bus(0, `VIC_OFF_CTRL, 0);
      `CHK("ctrl", 32'h12, d)
      bus(0, `VIC_OFF_PMASK_A, 0);
      `CHK("pmask_a", 32'h08, d)
      $display("t_sleep done");
    end
  endtask
  task results;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      mismatches++;
      results;
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    reset_i <= 0;
    t_reset;
    t_flags;
    t_vector;
    t_sleep;
    results;
  end
endmodule
